// ===== core/qvc_pkg.sv
// Purpose: Shared constants and types for the four-channel volume control logic.
// Assumes: System clock of 50 MHz on clk_i.
// Notes:   Long counts are also top-level parameters so a bench can shorten them.
package qvc_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned POR_MS          = 100;
  localparam int unsigned ZC_TIMEOUT_MS   = 16;
  localparam int unsigned POR_CYCLES      = (CLK_HZ / 1000) * POR_MS;
  localparam int unsigned ZC_CYCLES       = (CLK_HZ / 1000) * ZC_TIMEOUT_MS;
  localparam int unsigned CAL_CYCLES      = 64;
  localparam int unsigned NUM_CH          = 4;
  localparam int unsigned CODE_W          = 8;
  localparam int unsigned WORD_W          = NUM_CH * CODE_W;
  localparam logic [7:0]  GAIN_MUTE_CODE  = 8'h00;
  localparam logic [7:0]  GAIN_RESET_CODE = 8'h00;
  localparam logic [31:0] CH_MAP_DEFAULT  = 32'h0000_1b1b;

  typedef enum logic [2:0] {
    QVC_POR,
    QVC_CAL,
    QVC_RUN,
    QVC_BROWN
  } qvc_state_e;
endpackage : qvc_pkg

// ===== core/qvc_word_if.sv
// Purpose: Carries a finished serial word from the link domain to the core domain.
// Assumes: A toggle marks each new word; the word holds still until the next toggle.
// Notes:   Word bits are only sampled after the toggle has been synchronised.
`timescale 1ns/1ps
interface qvc_word_if;
  logic [31:0] word;
  logic        word_tgl;
  modport link (output word, output word_tgl);
  modport core (input word, input word_tgl);
endinterface : qvc_word_if

// ===== core/qvc_serial_link.sv
// Purpose: Shift register on the host shift clock with daisy-chain output.
// Assumes: The chip select pin is active low and sampled on the shift clock edges.
// Notes:   Chip select is taken asynchronously so the word latches when it rises.
`timescale 1ns/1ps
module qvc_serial_link
  import qvc_pkg::*;
(
  input  wire logic sclk_i,
  input  wire logic rstn_i,
  input  wire logic cs_n_i,
  input  wire logic serial_in_i,
  output logic      serial_out_o,
  output logic      serial_out_oe_o,
  qvc_word_if.link  wif
);
  logic [WORD_W-1:0] shift_q;
  logic              dout_q;
  logic              tgl_q;
  logic [WORD_W-1:0] held_q;

  // Bits shift only while selected. MSB lands at the top.
  // Reset is released while the shift clock idles, so its release needs no staging here.
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_q <= '0;
    end else if (!cs_n_i) begin
      shift_q <= {shift_q[WORD_W-2:0], serial_in_i};
    end
  end

  // Shifted-out bit leaves on the falling edge.
  always_ff @(negedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dout_q <= 1'b0;
    end else if (!cs_n_i) begin
      dout_q <= shift_q[WORD_W-1];
    end
  end

  // Word is handed over on the rising chip select, never mid-shift.
  always_ff @(posedge cs_n_i or negedge rstn_i) begin
    if (!rstn_i) begin
      held_q <= '0;
      tgl_q  <= 1'b0;
    end else begin
      held_q <= shift_q;
      tgl_q  <= ~tgl_q;
    end
  end

  assign serial_out_o    = dout_q;
  assign serial_out_oe_o = ~cs_n_i;
  assign wif.word        = held_q;
  assign wif.word_tgl    = tgl_q;
endmodule : qvc_serial_link

// ===== core/qvc_ch_gain.sv
// Purpose: One channel's pending and applied gain with zero-cross timing.
// Assumes: Zero-cross pulse is already synchronised to clk_i.
// Notes:   The timeout restarts whenever a new pending code arrives.
`timescale 1ns/1ps
module qvc_ch_gain
  import qvc_pkg::*;
#(
  parameter int unsigned TMO = ZC_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       clr_i,
  input  wire logic       load_i,
  input  wire logic [7:0] code_i,
  input  wire logic       zc_en_i,
  input  wire logic       zc_i,
  output logic [7:0]      gain_o
);
  if (TMO < 1) begin : g_bad_tmo
    $error("TMO must be at least one");
  end
  logic [7:0]  pend_q;
  logic        wait_q;
  logic [31:0] cnt_q;
  wire         expire = (cnt_q == 32'(TMO - 1));
  wire         apply  = wait_q && (!zc_en_i || zc_i || expire);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_q <= GAIN_RESET_CODE;
      wait_q <= 1'b0;
      cnt_q  <= '0;
      gain_o <= GAIN_RESET_CODE;
    end else if (clr_i) begin
      pend_q <= GAIN_RESET_CODE;
      wait_q <= 1'b0;
      cnt_q  <= '0;
      gain_o <= GAIN_RESET_CODE;
    end else if (load_i) begin
      pend_q <= code_i;
      wait_q <= 1'b1;
      cnt_q  <= '0;
    end else if (apply) begin
      gain_o <= pend_q;
      wait_q <= 1'b0;
    end else if (wait_q) begin
      cnt_q  <= cnt_q + 32'd1;
    end
  end
endmodule : qvc_ch_gain

// ===== core/qvc_top.sv
// Purpose: Four-channel volume control sequencing, mute and serial word capture.
// Assumes: clk_i is 50 MHz; sclk_i is the host shift clock.
// Notes:   Gain dB = 31.5 - 0.5*(255-code) is realised by the analog tap decoder.
// How it works
// - Hold power-up reset about 100ms, hardware-muted.
// - Then calibrate, then load all gains with zero.
// - Brown-out mutes; release reruns power-up.
// - Shift data only while chip select low.
// - Frame is 32 bits, four 8-bit codes.
// - MSB first, unsigned binary codes.
// - Sample serial input on rising shift clock.
// - Serial output high impedance while deselected.
// - Serial output changes on falling shift clock.
// - Code zero is software mute; code 192 is unity gain.
// - Codes 1-255 give 31.5-0.5(255-N) dB.
// - Shifted-out bits feed next chained device.
// - Zero-cross enable low disables synchronised changes.
// - Defer gain to zero crossing or 16ms.
// - Hardware mute waits crossing or 16ms always.
// - Hardware mute disconnects buffers, grounds outputs.
// - Each hardware mute starts offset calibration; here only a mute input fall while running does.
// - Mute input active low, enable active high.
`timescale 1ns/1ps
module qvc_top
  import qvc_pkg::*;
#(
  parameter int unsigned POR_CNT = POR_CYCLES,
  parameter int unsigned ZC_CNT  = ZC_CYCLES,
  parameter int unsigned CAL_CNT = CAL_CYCLES,
  parameter logic [31:0] CH_MAP  = CH_MAP_DEFAULT
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        serial_in_i,
  output logic             serial_out_o,
  output logic             serial_out_oe_o,
  input  wire logic        mute_n_i,
  input  wire logic        zero_cross_enable_i,
  input  wire logic        brownout_i,
  input  wire logic [3:0]  zero_cross_i,
  input  wire logic        cal_done_i,
  output logic             cal_start_o,
  output logic             hw_mute_o,
  output logic [3:0]       sw_mute_o,
  output logic [31:0]      gain_o
);
  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // A zero count would wrap the terminal compare to all ones and stall the sequencer or the zero-cross timeouts.
  if (POR_CNT < 1) begin : g_bad_por
    $error("POR_CNT must be at least one");
  end
  if (ZC_CNT < 1) begin : g_bad_zc
    $error("ZC_CNT must be at least one");
  end
  if (CAL_CNT < 1) begin : g_bad_cal
    $error("CAL_CNT must be at least one");
  end
  // The gain port and the serial word are fixed at four 8-bit codes.
  if (WORD_W != 32 || CODE_W != 8) begin : g_bad_word
    $error("word layout must be four 8-bit codes");
  end

  // ****************************************************************
  // Serial link on the host shift clock
  // ****************************************************************
  // Only the toggle is synchronised; the word holds still from chip select rising until the
  // next frame ends, long after the toggle has crossed, so it is read without staging.
  qvc_word_if wif ();
  logic sdo_raw;
  logic sdo_oe_raw;

  qvc_serial_link u_link (
    .sclk_i          (sclk_i),
    .rstn_i          (rstn_i),
    .cs_n_i          (cs_n_i),
    .serial_in_i     (serial_in_i),
    .serial_out_o    (sdo_raw),
    .serial_out_oe_o (sdo_oe_raw),
    .wif             (wif)
  );

  // The chain output must track the shift clock, so it bypasses the core flops.
  assign serial_out_o    = sdo_raw;
  assign serial_out_oe_o = sdo_oe_raw;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Stage registers per asynchronous input; the level flops below are what the core reads.
  logic [2:0] tgl_s;
  logic [2:0] mute_s;
  logic [2:0] zce_s;
  logic [2:0] bo_s;
  logic [2:0] cal_s;
  logic [3:0] zc_s0;
  logic [3:0] zc_s1;
  logic [3:0] zc_s2;
  logic       tgl_prev_q;
  logic [3:0] zc_lvl_q;
  logic       mute_lvl_q;
  logic       zce_lvl_q;
  logic       bo_lvl_q;
  logic       cal_lvl_q;
  wire  [3:0] zc_agree = zc_s2 ~^ zc_s1;

  // Mute idles high, so its stages reset high and no false mute edge follows reset.
  // The first stage may go metastable; only the last two, once they agree, move a level.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tgl_s  <= '0;
      mute_s <= 3'h7;
      zce_s  <= '0;
      bo_s   <= '0;
      cal_s  <= '0;
      zc_s0  <= '0;
      zc_s1  <= '0;
      zc_s2  <= '0;
    end else begin
      tgl_s  <= {tgl_s[1:0], wif.word_tgl};
      mute_s <= {mute_s[1:0], mute_n_i};
      zce_s  <= {zce_s[1:0], zero_cross_enable_i};
      bo_s   <= {bo_s[1:0], brownout_i};
      cal_s  <= {cal_s[1:0], cal_done_i};
      zc_s0  <= zero_cross_i;
      zc_s1  <= zc_s0;
      zc_s2  <= zc_s1;
    end
  end

  // A level changes only once the second and third stages agree.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tgl_prev_q <= 1'b0;
      mute_lvl_q <= 1'b1;
      zce_lvl_q  <= 1'b0;
      bo_lvl_q   <= 1'b0;
      cal_lvl_q  <= 1'b0;
      zc_lvl_q   <= '0;
    end else begin
      if (tgl_s[2] == tgl_s[1]) tgl_prev_q <= tgl_s[2];
      if (mute_s[2] == mute_s[1]) mute_lvl_q <= mute_s[2];
      if (zce_s[2] == zce_s[1]) zce_lvl_q <= zce_s[2];
      if (bo_s[2] == bo_s[1]) bo_lvl_q <= bo_s[2];
      if (cal_s[2] == cal_s[1]) cal_lvl_q <= cal_s[2];
      zc_lvl_q <= (zc_agree & zc_s2) | (~zc_agree & zc_lvl_q);
    end
  end

  // ****************************************************************
  // Edge detection on the synchronised levels
  // ****************************************************************
  // Previous-value flops reset to each pin's idle level, so no false edge follows reset.
  logic tgl_seen_q;
  logic mute_prev_q;
  logic cal_prev_q;
  logic [3:0] zc_prev_q;
  // A word event is a toggle that has settled in the core domain.
  wire  word_evt   = (tgl_prev_q != tgl_seen_q);
  wire  hw_mute_rq = ~mute_lvl_q;
  wire  mute_fall  = mute_prev_q & ~mute_lvl_q;
  wire  cal_rise   = cal_lvl_q & ~cal_prev_q;
  wire [3:0] zc_pos = zc_lvl_q & ~zc_prev_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tgl_seen_q  <= 1'b0;
      mute_prev_q <= 1'b1;
      cal_prev_q  <= 1'b0;
      zc_prev_q   <= '0;
    end else begin
      tgl_seen_q  <= tgl_prev_q;
      mute_prev_q <= mute_lvl_q;
      cal_prev_q  <= cal_lvl_q;
      zc_prev_q   <= zc_lvl_q;
    end
  end

  // ****************************************************************
  // Power-up, brown-out and calibration sequencing
  // ****************************************************************
  qvc_state_e  state_q;
  qvc_state_e  state_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        clr_gain;
  wire         por_done = (cnt_q == 32'(POR_CNT - 1));
  wire         cal_tmo  = (cnt_q == 32'(CAL_CNT - 1));
  wire         cal_end  = cal_rise | cal_tmo;

  // One counter serves the power-up delay and the calibration timeout; it rests at zero elsewhere.
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q + 32'd1;
    clr_gain = 1'b0;
    case (state_q)
      QVC_POR: begin
        // A brown-out here restarts the full delay from its release.
        if (bo_lvl_q) begin
          cnt_d = '0;
        end else if (por_done) begin
          state_d = QVC_CAL;
          cnt_d   = '0;
        end
      end
      QVC_CAL: begin
        // The timeout keeps a missing done pulse from hanging start-up.
        if (bo_lvl_q) begin
          state_d = QVC_BROWN;
        end else if (cal_end) begin
          state_d  = QVC_RUN;
          clr_gain = 1'b1;
        end
      end
      QVC_RUN: begin
        cnt_d = '0;
        if (bo_lvl_q) begin
          state_d = QVC_BROWN;
        end
      end
      default: begin
        // Brown-out: wait here until the supply indication clears.
        cnt_d = '0;
        if (!bo_lvl_q) begin
          state_d = QVC_POR;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= QVC_POR;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Brown-out looks like power-up at the outputs: muted, gains cleared.
  wire in_por = (state_q == QVC_POR) || (state_q == QVC_BROWN);
  wire running = (state_q == QVC_RUN);

  // ****************************************************************
  // Hardware mute with zero-cross or timeout
  // ****************************************************************
  logic        hm_q;
  logic        hm_pend_q;
  logic [31:0] hm_cnt_q;
  logic        cal_pulse_q;
  // The timeout counter only runs while a mute is pending.
  wire         hm_tmo = (hm_cnt_q == 32'(ZC_CNT - 1));
  wire         hm_go  = hm_pend_q && ((|zc_pos) || hm_tmo);
  wire         por_exit = (state_q == QVC_POR) && por_done && !bo_lvl_q;
  wire         mute_cal = running && mute_fall;

  // Unmute acts at once; only the mute edge waits for a crossing or the timeout.
  // A crossing on any channel is taken, since all outputs are switched together.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hm_q      <= 1'b1;
      hm_pend_q <= 1'b0;
      hm_cnt_q  <= '0;
    end else if (in_por) begin
      hm_q      <= 1'b1;
      hm_pend_q <= 1'b0;
      hm_cnt_q  <= '0;
    end else if (!hw_mute_rq) begin
      hm_q      <= 1'b0;
      hm_pend_q <= 1'b0;
      hm_cnt_q  <= '0;
    end else if (mute_fall) begin
      hm_pend_q <= 1'b1;
      hm_cnt_q  <= '0;
    end else if (hm_go) begin
      hm_q      <= 1'b1;
      hm_pend_q <= 1'b0;
    end else if (hm_pend_q) begin
      hm_cnt_q  <= hm_cnt_q + 32'd1;
    end
  end

  // Calibration start pulses after power-up and on each mute assertion while running.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cal_pulse_q <= 1'b0;
    end else begin
      cal_pulse_q <= por_exit || mute_cal;
    end
  end

  // ****************************************************************
  // Channel gain registers
  // ****************************************************************
  // Words that finish outside the run state are dropped, never queued for later.
  logic [31:0] gain_w;
  wire  [3:0]  mute_w;
  wire         load = word_evt & running;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    // Each channel picks its byte through the map, so board wiring can be matched freely.
    wire [1:0] byte_sel = CH_MAP[2*ch +: 2];
    wire [7:0] code     = wif.word[8*byte_sel +: 8];
    assign mute_w[ch] = (gain_w[8*ch +: 8] == GAIN_MUTE_CODE);
    qvc_ch_gain #(
      .TMO (ZC_CNT)
    ) u_gain (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .clr_i   (clr_gain | in_por),
      .load_i  (load),
      .code_i  (code),
      .zc_en_i (zce_lvl_q),
      .zc_i    (zc_pos[ch]),
      .gain_o  (gain_w[8*ch +: 8])
    );
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // One more register stage puts every clk_i-domain port on a flop; a cycle of delay is inaudible.
  // Soft mute follows the applied code, not the pending one.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cal_start_o <= 1'b0;
      hw_mute_o   <= 1'b1;
      sw_mute_o   <= 4'hf;
      gain_o      <= '0;
    end else begin
      cal_start_o <= cal_pulse_q;
      hw_mute_o   <= hm_q;
      gain_o      <= gain_w;
      sw_mute_o   <= mute_w;
    end
  end
endmodule : qvc_top

// ===== dv/qvc_top_properties.sv
// Purpose: Port timing checks for the volume control top.
// Assumes: Bench holds mute low until the mute has landed.
// Notes:   Bound into qvc_top from the bench top file.
`timescale 1ns/1ps
module qvc_top_properties #(
  parameter int unsigned ZC_CNT = 40
) (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        cs_n_i,
  input wire logic        serial_out_oe_o,
  input wire logic        mute_n_i,
  input wire logic        brownout_i,
  input wire logic        cal_start_o,
  input wire logic        hw_mute_o,
  input wire logic [3:0]  sw_mute_o,
  input wire logic [31:0] gain_o
);
  // Margin covers the input synchronisers ahead of the timeout count.
  localparam int MUTE_MAX = ZC_CNT + 12;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_oe; serial_out_oe_o == !cs_n_i; endproperty
  a_oe: assert property (p_oe) else $error("serial out enable wrong");
  property p_por; $rose(rstn_i) |-> (hw_mute_o && gain_o == 32'h0) [*8]; endproperty
  a_por: assert property (p_por) else $error("not muted after reset");
  property p_swm;
    sw_mute_o == {gain_o[31:24] == 8'h00, gain_o[23:16] == 8'h00, gain_o[15:8] == 8'h00, gain_o[7:0] == 8'h00};
  endproperty
  a_swm: assert property (p_swm) else $error("soft mute flags wrong");
  property p_brown; $rose(brownout_i) |-> ##[1:8] (hw_mute_o && gain_o == 32'h0); endproperty
  a_brown: assert property (p_brown) else $error("brown-out not muted");
  property p_cal1; cal_start_o |=> !cal_start_o; endproperty
  a_cal1: assert property (p_cal1) else $error("calibration start too long");
  property p_mcal; $fell(mute_n_i) && !hw_mute_o |-> ##[1:8] cal_start_o; endproperty
  a_mcal: assert property (p_mcal) else $error("mute gave no calibration");
  property p_mtmo; $fell(mute_n_i) && !hw_mute_o && !brownout_i |-> ##[1:MUTE_MAX] hw_mute_o; endproperty
  a_mtmo: assert property (p_mtmo) else $error("mute late");
  property p_unm; $rose(mute_n_i) && hw_mute_o && !brownout_i |-> ##[1:10] !hw_mute_o; endproperty
  a_unm: assert property (p_unm) else $error("unmute late");
endmodule : qvc_top_properties

// ===== dv/qvc_host_model.sv
// Purpose: Host side of the serial port, shifting frames MSB first.
// Assumes: Shift clock idles low and runs only inside frames.
// Notes:   Data in is inverted on release so a stale value never reads back.
`timescale 1ns/1ps
module qvc_host_model (
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic            serial_in_o,
  input  wire logic       serial_out_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    serial_in_o = 1'b0;
  end
  // Frame of n bits from d[63] down; sel low shifts with the port deselected.
  task automatic frame(input logic [63:0] d, input int n, input logic sel, output logic [63:0] rx);
    rx = '0;
    cs_n_o = !sel;
    #100;
    for (int i = 0; i < n; i++) begin
      serial_in_o = d[63-i];
      #7.5 sclk_o = 1'b1;
      rx = {rx[62:0], serial_out_i};
      #7.5 sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    serial_in_o = ~serial_in_o;
  endtask : frame
endmodule : qvc_host_model

// ===== dv/quad_volume_serial_control_tb_top.sv
// Purpose: Self-checking bench for the volume control top.
// Assumes: Counts shortened to POR 50 and zero-cross timeout 40 cycles.
// Notes:   Calibration done is answered five cycles after each start.
`timescale 1ns/1ps
module quad_volume_serial_control_tb_top;
  import qvc_pkg::*;
  localparam int unsigned POR_N = 50;
  localparam int unsigned ZC_N  = 40;
  logic        clk_i = 0, rstn_i = 0, mute_n_i = 1, zero_cross_enable_i = 0;
  logic        brownout_i = 0, cal_done_i = 0, sclk, cs_n, serial_in, serial_out, sdo_oe;
  logic        cal_start_o, hw_mute_o;
  logic [3:0]  zero_cross_i = 0, sw_mute_o;
  logic [31:0] gain_o, exp_g, w, t, seed = 32'h731f35c1;
  logic [63:0] rx;
  logic        chain_q[$];
  int          bad_count = 0, checks = 0, k;
  always #10 clk_i = ~clk_i;
  // A released serial out shows the inverse of its last bit, so a missing enable cannot pass.
  qvc_host_model u_qvc_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .serial_in_o(serial_in),
    .serial_out_i(sdo_oe ? serial_out : ~serial_out));
  qvc_top #(.POR_CNT(POR_N), .ZC_CNT(ZC_N)) u_qvc_top (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .serial_in_i(serial_in), .serial_out_o(serial_out), .serial_out_oe_o(sdo_oe), .mute_n_i(mute_n_i),
    .zero_cross_enable_i(zero_cross_enable_i), .brownout_i(brownout_i), .zero_cross_i(zero_cross_i),
    .cal_done_i(cal_done_i), .cal_start_o(cal_start_o), .hw_mute_o(hw_mute_o), .sw_mute_o(sw_mute_o),
    .gain_o(gain_o));
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  function automatic logic [31:0] chmap(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction : chmap
  task automatic clks(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : clks
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic wait_run();
    k = 0;
    while (hw_mute_o !== 1'b0 && k < 400) begin
      clks(1);
      k++;
    end
    chk("mute", 32'h0, {31'h0, hw_mute_o});
  endtask : wait_run
  // The chain model is a 32-bit delay line: each bit leaves 32 shifts after it entered.
  task automatic send(input logic [31:0] v);
    logic [63:0] f;
    logic [63:0] e;
    t = rnd();
    f = {t, v};
    e = '0;
    for (int i = 63; i >= 0; i--) chain_q.push_back(f[i]);
    for (int i = 0; i < 64; i++) e = {e[62:0], chain_q.pop_front()};
    u_qvc_host_model.frame(f, 64, 1'b1, rx);
    chk("chain", e[31:0], rx[31:0]);
    chk("chain old", e[63:32], rx[63:32]);
  endtask : send
  always begin
    @(posedge clk_i iff cal_start_o === 1'b1);
    clks(5);
    cal_done_i = 1;
    clks(2);
    cal_done_i = 0;
  end
  initial begin
    #200000;
    bad_count++;
    $display("test watchdog expired");
    tally_and_finish();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    // The link's shift register resets to zero.
    repeat (32) chain_q.push_back(1'b0);
    clks(3);
    rstn_i = 1;
    wait_run();
    chk("gain", 32'h0, gain_o);
    chk("swm", 32'hf, {28'h0, sw_mute_o});
    $display("test power-up done");
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 32'h00ff01fe : rnd();
      send(w);
      exp_g = chmap(w);
      clks(12);
      chk("gain", exp_g, gain_o);
    end
    u_qvc_host_model.frame({rnd(), rnd()}, 64, 1'b0, rx);
    clks(12);
    chk("gain", exp_g, gain_o);
    $display("test write done");
    zero_cross_enable_i = 1;
    w = ~exp_g;
    send(w);
    clks(12);
    chk("hold", exp_g, gain_o);
    zero_cross_i = 4'h1;
    clks(2);
    zero_cross_i = 4'h0;
    clks(6);
    t = chmap(w);
    exp_g[7:0] = t[7:0];
    chk("zc", exp_g, gain_o);
    clks(ZC_N + 10);
    exp_g = t;
    chk("tmo", exp_g, gain_o);
    $display("test zero-cross done");
    zero_cross_enable_i = 0;
    mute_n_i = 0;
    clks(10);
    zero_cross_i = 4'h4;
    clks(2);
    zero_cross_i = 4'h0;
    clks(6);
    chk("hmute", 32'h1, {31'h0, hw_mute_o});
    clks(20);
    mute_n_i = 1;
    clks(12);
    chk("unmute", 32'h0, {31'h0, hw_mute_o});
    chk("gain", exp_g, gain_o);
    $display("test mute done");
    brownout_i = 1;
    clks(10);
    chk("bo mute", 32'h1, {31'h0, hw_mute_o});
    chk("bo gain", 32'h0, gain_o);
    brownout_i = 0;
    u_qvc_host_model.frame({rnd(), 32'h0}, 32, 1'b1, rx);
    clks(5);
    wait_run();
    chk("gain", 32'h0, gain_o);
    $display("test brown-out done");
    tally_and_finish();
  end
endmodule : quad_volume_serial_control_tb_top
bind qvc_top qvc_top_properties #(.ZC_CNT(ZC_CNT)) u_qvc_top_properties (.clk_i(clk_i), .rstn_i(rstn_i),
  .cs_n_i(cs_n_i), .serial_out_oe_o(serial_out_oe_o), .mute_n_i(mute_n_i), .brownout_i(brownout_i),
  .cal_start_o(cal_start_o), .hw_mute_o(hw_mute_o), .sw_mute_o(sw_mute_o), .gain_o(gain_o));
